// ---- src/uart_irq_fifo_map.svh ----
// register offsets, field positions and reset values of the irq/fifo block
`ifndef UART_IRQ_FIFO_MAP_SVH
`define UART_IRQ_FIFO_MAP_SVH

// byte addresses on the register port
`define OFS_DIVISOR_LOW 32'h50001100
`define OFS_IRQ_EN_DIV_HIGH 32'h50001104
`define OFS_IDENT_FIFO_CTRL 32'h50001108
`define OFS_LINE_CTRL 32'h5000110C

// interrupt enable field positions
`define EN_PROG_EMPTY_BIT 7
`define EN_MODEM_BIT 3
`define EN_LINE_BIT 2
`define EN_HOLD_EMPTY_BIT 1
`define EN_RX_AVAIL_BIT 0

// fifo control field positions
`define CTL_RX_TRIG_HI 7
`define CTL_RX_TRIG_LO 6
`define CTL_TX_THR_HI 5
`define CTL_TX_THR_LO 4
`define CTL_DMA_MODE_BIT 3
`define CTL_TX_FLUSH_BIT 2
`define CTL_RX_FLUSH_BIT 1
`define CTL_FIFO_EN_BIT 0

// line control: only the divisor access bit lives here
`define LINE_DIV_ACCESS_BIT 7

// identification high bits
`define FIFO_STATE_ON 2'h3
`define FIFO_STATE_OFF 2'h0

// reset values
`define BYTE_RESET 8'h00
`define DIVISOR_RESET 16'h0000
`define READ_ZERO 16'h0000

// fixed figures used by the trigger tables and the baud generator
`define RX_TRIG_MARGIN 2
`define TX_THR_TWO 2
`define DIVISOR_ONE 16'h0001
`define BIT_TICKS_LAST 4'hF

`endif

// ---- src/uart_irq_fifo_pkg.sv ----
// types shared by the interrupt enable / fifo control block
package uart_irq_fifo_pkg;

  // pending interrupt codes, listed by code value, not by priority
  typedef enum logic [3:0] {
    CODE_MODEM = 4'h0,
    CODE_NONE = 4'h1,
    CODE_HOLD_EMPTY = 4'h2,
    CODE_RX_AVAIL = 4'h4,
    CODE_LINE_STATUS = 4'h6,
    CODE_BUSY = 4'h7,
    CODE_CHAR_TIMEOUT = 4'hC
  } irq_ident_code_t;

  typedef struct packed {
    logic prog_holding_empty_mode_en;
    logic modem_status_irq_en;
    logic line_status_irq_en;
    logic holding_empty_irq_en;
    logic rx_available_irq_en;
  } irq_enable_t;

  typedef struct packed {
    logic [1:0] rx_trigger_level;
    logic [1:0] tx_empty_threshold;
    logic dma_signalling_select;
    logic fifo_enable_bit;
  } fifo_ctrl_t;

  // pending conditions raised by the neighbouring uart logic
  typedef struct packed {
    logic line_status;
    logic modem_status;
    logic char_timeout;
    logic busy_detect;
  } irq_cause_t;

  typedef struct packed {
    logic tx_fifo_flush;
    logic rx_fifo_flush;
  } flush_t;

endpackage

// ---- src/uart_irq_fifo_ctrl.sv ----
// interrupt enable, divisor high byte, identification and fifo control
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "uart_irq_fifo_map.svh"

module uart_irq_fifo_ctrl #(
  parameter int DEPTH = 16, // fifo depth in characters
  parameter int LW = 5 // width of the fifo level counts
) (
  input wire logic ref_clk, // system clock, 100 MHz
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic [31:0] reg_addr, // byte address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  input wire uart_irq_fifo_pkg::irq_cause_t cause, // pending sources
  input wire logic [LW-1:0] rx_level, // receive fifo fill
  input wire logic [LW-1:0] tx_level, // transmit fifo fill
  input wire logic tx_holding_empty, // holding register empty, no fifo
  input wire logic auto_flow_en, // automatic flow control on
  input wire logic rts_request, // software request to send
  output logic irq, // interrupt, active high
  output logic rts_n, // request to send, active low
  output logic dma_rx_req_n, // receive dma request, active low
  output logic dma_tx_req_n, // transmit dma request, active low
  output uart_irq_fifo_pkg::flush_t flush, // one-cycle flush pulses
  output logic fifos_enabled_flag, // fifos in use
  output uart_irq_fifo_pkg::irq_enable_t irq_enable, // enable bits
  output uart_irq_fifo_pkg::fifo_ctrl_t fifo_ctrl, // fifo settings
  output logic divisor_access_bit, // divisor access selected
  output logic [15:0] baud_divisor, // full baud divisor
  output logic baud_x16_tick, // one pulse per sixteenth bit
  output logic baud_bit_tick // one pulse per bit time
);
  import uart_irq_fifo_pkg::*;

  // refuse fifo sizes the trigger tables cannot serve
  if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("uart_irq_fifo_ctrl: DEPTH must be a power of two >= 8");
  end
  // level counts must reach DEPTH itself, which needs one spare bit
  if (LW != $clog2(DEPTH) + 1) begin : g_bad_width
    $error("uart_irq_fifo_ctrl: LW must be clog2(DEPTH) + 1");
  end

  // fill levels the trigger and threshold tables compare against
  localparam logic [LW-1:0] LVL_ZERO = LW'(0);
  localparam logic [LW-1:0] LVL_ONE = LW'(1);
  localparam logic [LW-1:0] LVL_QUARTER = LW'(DEPTH / 4);
  localparam logic [LW-1:0] LVL_HALF = LW'(DEPTH / 2);
  localparam logic [LW-1:0] LVL_FULL = LW'(DEPTH);
  localparam logic [LW-1:0] LVL_FULL_M2 = LW'(DEPTH - `RX_TRIG_MARGIN);
  localparam logic [LW-1:0] LVL_TWO = LW'(`TX_THR_TWO);

  // registers and their next values
  irq_enable_t irq_enable_reg, irq_enable_next;
  fifo_ctrl_t fifo_ctrl_reg, fifo_ctrl_next;
  flush_t flush_reg, flush_next;
  logic [7:0] divisor_low_reg, divisor_low_next;
  logic [7:0] divisor_high_byte, divisor_high_next;
  logic divisor_access_reg, divisor_access_next;
  logic [15:0] rdata_reg, rdata_next;
  logic irq_reg, rts_n_reg, dma_rx_reg, dma_tx_reg;
  logic dma_rx_next, dma_tx_next;
  logic [15:0] div_cnt_reg, div_cnt_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic x16_reg, x16_next, bit_reg, bit_next;

  // address decode
  wire hit_div_low = reg_addr == `OFS_DIVISOR_LOW;
  wire hit_irq_en = reg_addr == `OFS_IRQ_EN_DIV_HIGH;
  wire hit_ident = reg_addr == `OFS_IDENT_FIFO_CTRL;
  wire hit_line = reg_addr == `OFS_LINE_CTRL;
  wire dla = divisor_access_reg;
  // divisor low byte only reachable with divisor access set
  wire wr_div_low = reg_wr & hit_div_low & dla;
  wire wr_div_high = reg_wr & hit_irq_en & dla;
  wire wr_irq_en = reg_wr & hit_irq_en & ~dla;
  wire wr_fifo_ctrl = reg_wr & hit_ident;
  wire wr_line = reg_wr & hit_line;

  // write side: register next values
  assign divisor_low_next = wr_div_low ? reg_wdata[7:0] : divisor_low_reg;
  assign divisor_high_next = wr_div_high ? reg_wdata[7:0]
                                         : divisor_high_byte;
  assign divisor_access_next = wr_line ? reg_wdata[`LINE_DIV_ACCESS_BIT]
                                       : divisor_access_reg;
  assign irq_enable_next = wr_irq_en ? irq_enable_t'({
      reg_wdata[`EN_PROG_EMPTY_BIT],
      reg_wdata[`EN_MODEM_BIT],
      reg_wdata[`EN_LINE_BIT],
      reg_wdata[`EN_HOLD_EMPTY_BIT],
      reg_wdata[`EN_RX_AVAIL_BIT]})
    : irq_enable_reg;
  assign fifo_ctrl_next = wr_fifo_ctrl ? fifo_ctrl_t'({
      reg_wdata[`CTL_RX_TRIG_HI:`CTL_RX_TRIG_LO],
      reg_wdata[`CTL_TX_THR_HI:`CTL_TX_THR_LO],
      reg_wdata[`CTL_DMA_MODE_BIT],
      reg_wdata[`CTL_FIFO_EN_BIT]})
    : fifo_ctrl_reg;
  // flush bits are never stored, so they clear themselves
  assign flush_next.tx_fifo_flush = wr_fifo_ctrl
                                    & reg_wdata[`CTL_TX_FLUSH_BIT];
  assign flush_next.rx_fifo_flush = wr_fifo_ctrl
                                    & reg_wdata[`CTL_RX_FLUSH_BIT];

  // fifo thresholds from the stored selections
  wire fifo_on = fifo_ctrl_reg.fifo_enable_bit;
  logic [LW-1:0] rx_trig, tx_thr;
  always_comb begin
    case (fifo_ctrl_reg.rx_trigger_level)
      2'h0: rx_trig = LVL_ONE;
      2'h1: rx_trig = LVL_QUARTER;
      2'h2: rx_trig = LVL_HALF;
      default: rx_trig = LVL_FULL_M2;
    endcase
    case (fifo_ctrl_reg.tx_empty_threshold)
      2'h0: tx_thr = LVL_ZERO;
      2'h1: tx_thr = LVL_TWO;
      2'h2: tx_thr = LVL_QUARTER;
      default: tx_thr = LVL_HALF;
    endcase
  end

  // pending conditions before enables
  wire rx_any = rx_level != LVL_ZERO;
  wire rx_at_trig = rx_level >= rx_trig;
  wire tx_empty = fifo_on ? (tx_level == LVL_ZERO) : tx_holding_empty;
  wire prog_mode = irq_enable_reg.prog_holding_empty_mode_en & fifo_on;
  // programmable mode swaps plain empty for the threshold test
  wire tx_low = prog_mode ? (tx_level <= tx_thr) : tx_empty;
  wire rx_avail = fifo_on ? rx_at_trig : rx_any;
  wire timeout = cause.char_timeout & fifo_on;

  // enabled sources, gated one by one; busy has no enable
  wire p_line = cause.line_status & irq_enable_reg.line_status_irq_en;
  wire p_rx = rx_avail & irq_enable_reg.rx_available_irq_en;
  wire p_tmo = timeout & irq_enable_reg.rx_available_irq_en;
  wire p_hold = tx_low & irq_enable_reg.holding_empty_irq_en;
  wire p_modem = cause.modem_status
                 & irq_enable_reg.modem_status_irq_en;
  wire p_busy = cause.busy_detect;

  // fixed priority: line, rx data/timeout, holding empty, modem, busy
  irq_ident_code_t ident;
  assign ident = p_line ? CODE_LINE_STATUS
               : p_rx ? CODE_RX_AVAIL
               : p_tmo ? CODE_CHAR_TIMEOUT
               : p_hold ? CODE_HOLD_EMPTY
               : p_modem ? CODE_MODEM
               : p_busy ? CODE_BUSY
               : CODE_NONE;
  wire [1:0] fifo_state = fifo_on ? `FIFO_STATE_ON
                                  : `FIFO_STATE_OFF;

  // read mux; reserved and unmapped bits read zero
  wire [15:0] rd_irq_en = {8'h00, irq_enable_reg.prog_holding_empty_mode_en,
    3'h0, irq_enable_reg.modem_status_irq_en,
    irq_enable_reg.line_status_irq_en, irq_enable_reg.holding_empty_irq_en,
    irq_enable_reg.rx_available_irq_en};
  wire [15:0] rd_ident = {8'h00, fifo_state, 2'h0, ident};
  wire [15:0] rd_line = {8'h00, divisor_access_reg, 7'h00};
  assign rdata_next = !reg_rd ? `READ_ZERO
    : (hit_div_low && dla) ? {8'h00, divisor_low_reg}
    : (hit_irq_en && dla) ? {8'h00, divisor_high_byte}
    : hit_irq_en ? rd_irq_en
    : hit_ident ? rd_ident
    : hit_line ? rd_line
    : `READ_ZERO;

  // dma mode 0 follows one character; mode 1 uses the thresholds
  wire dma_mode1 = fifo_ctrl_reg.dma_signalling_select & fifo_on;
  wire rx_dma_set = dma_mode1 ? (rx_at_trig | timeout) : rx_any;
  wire rx_dma_keep = dma_mode1 & dma_rx_reg & rx_any;
  wire tx_dma_set = dma_mode1 ? (tx_level <= tx_thr) : tx_empty;
  wire tx_dma_keep = dma_mode1 & dma_tx_reg & (tx_level != LVL_FULL);

  // mode 1 holds a request until the fifo drains or fills
  assign dma_rx_next = rx_dma_set | rx_dma_keep;
  assign dma_tx_next = tx_dma_set | tx_dma_keep;

  // rts drops at the receive trigger under automatic flow control
  wire flow_stop = auto_flow_en & fifo_on & rx_at_trig;
  wire rts_n_next = ~rts_request | flow_stop;

  // interrupt while any enabled source pends; busy is never masked
  wire irq_next = ident != CODE_NONE;

  // baud generator: divisor counts clocks per sixteenth of a bit
  wire [15:0] divisor = {divisor_high_byte, divisor_low_reg};
  wire div_run = divisor != `DIVISOR_RESET;
  wire div_wrap = div_run && (div_cnt_reg >= divisor - `DIVISOR_ONE);
  // a zero divisor parks the generator instead of dividing by zero
  assign div_cnt_next = (!div_run || div_wrap) ? `DIVISOR_RESET
                        : div_cnt_reg + `DIVISOR_ONE;

  // sixteen sixteenths make one bit time
  assign x16_next = div_wrap;
  assign bit_cnt_next = !div_run ? 4'h0
                        : div_wrap ? bit_cnt_reg + 4'h1 : bit_cnt_reg;
  assign bit_next = div_wrap && (bit_cnt_reg == `BIT_TICKS_LAST);

  // interrupt enable bits
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_enable_reg <= '0;
    end else begin
      irq_enable_reg <= irq_enable_next;
    end
  end

  // fifo control selections
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fifo_ctrl_reg <= '0;
    end else begin
      fifo_ctrl_reg <= fifo_ctrl_next;
    end
  end

  // divisor low byte
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      divisor_low_reg <= `BYTE_RESET;
    end else begin
      divisor_low_reg <= divisor_low_next;
    end
  end

  // divisor high byte, shares the enable offset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      divisor_high_byte <= `BYTE_RESET;
    end else begin
      divisor_high_byte <= divisor_high_next;
    end
  end

  // divisor access select
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      divisor_access_reg <= 1'b0;
    end else begin
      divisor_access_reg <= divisor_access_next;
    end
  end

  // read data, zero outside its answer cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= `READ_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // flush pulses, one cycle each
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flush_reg <= '0;
    end else begin
      flush_reg <= flush_next;
    end
  end

  // interrupt, registered so no decode glitch leaves the block
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // request to send, idle high
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rts_n_reg <= 1'b1;
    end else begin
      rts_n_reg <= rts_n_next;
    end
  end

  // receive dma request
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_rx_reg <= 1'b0;
    end else begin
      dma_rx_reg <= dma_rx_next;
    end
  end

  // transmit dma request
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_tx_reg <= 1'b0;
    end else begin
      dma_tx_reg <= dma_tx_next;
    end
  end

  // clocks within one sixteenth of a bit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_reg <= `DIVISOR_RESET;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  // sixteenths within one bit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_reg <= 4'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // sixteenth tick
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      x16_reg <= 1'b0;
    end else begin
      x16_reg <= x16_next;
    end
  end

  // bit tick
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_reg <= 1'b0;
    end else begin
      bit_reg <= bit_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;
  assign rts_n = rts_n_reg;
  assign dma_rx_req_n = ~dma_rx_reg;
  assign dma_tx_req_n = ~dma_tx_reg;
  assign flush = flush_reg;
  assign fifos_enabled_flag = fifo_ctrl_reg.fifo_enable_bit;
  assign irq_enable = irq_enable_reg;
  assign fifo_ctrl = fifo_ctrl_reg;
  assign divisor_access_bit = divisor_access_reg;
  assign baud_divisor = {divisor_high_byte, divisor_low_reg};
  assign baud_x16_tick = x16_reg;
  assign baud_bit_tick = bit_reg;

endmodule

// ---- verification/uart_fifo_peer.sv ----
// far-side model: fifo fill levels and line events seen by the block
`timescale 1ns/1ps
module uart_fifo_peer #(
  parameter int LW = 5 // level width
) (
  input wire logic ref_clk, // system clock
  input wire logic arst_n, // reset, active low
  input wire logic load, // take new fill and event values
  input wire logic [LW-1:0] rx_set, // receive fill to load
  input wire logic [LW-1:0] tx_set, // transmit fill to load
  input wire uart_irq_fifo_pkg::irq_cause_t cause_set, // events to load
  input wire uart_irq_fifo_pkg::flush_t flush, // flush pulses from block
  output logic [LW-1:0] rx_level, // receive fill
  output logic [LW-1:0] tx_level, // transmit fill
  output logic tx_holding_empty, // holding register empty
  output uart_irq_fifo_pkg::irq_cause_t cause // pending line events
);
  import uart_irq_fifo_pkg::*;
  // without fifos the holding register is empty when nothing is queued
  assign tx_holding_empty = (tx_level == '0);
  // a flush beats a load: the fifo must read as empty at once
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_level <= '0;
      tx_level <= '0;
      cause <= '0;
    end else begin
      if (load) begin
        rx_level <= rx_set;
        tx_level <= tx_set;
        cause <= cause_set;
      end
      if (flush.rx_fifo_flush) rx_level <= '0;
      if (flush.tx_fifo_flush) tx_level <= '0;
    end
  end
endmodule

// ---- verification/uart_irq_fifo_props.sv ----
// port-level assertions for the irq enable / fifo control block
`timescale 1ns/1ps
`include "uart_irq_fifo_map.svh"
module uart_irq_fifo_props #(
  parameter int DEPTH = 16, // fifo depth
  parameter int LW = 5 // level width
) (
  input wire logic ref_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic [31:0] reg_addr, // byte address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_rdata, // read data
  input wire uart_irq_fifo_pkg::irq_cause_t cause, // pending sources
  input wire logic [LW-1:0] rx_level, // receive fill
  input wire logic auto_flow_en, // automatic flow control
  input wire logic rts_request, // software rts
  input wire logic irq, // interrupt
  input wire logic rts_n, // rts, active low
  input wire logic dma_rx_req_n, // receive dma request
  input wire uart_irq_fifo_pkg::flush_t flush, // flush pulses
  input wire logic fifos_enabled_flag, // fifos in use
  input wire uart_irq_fifo_pkg::irq_enable_t irq_enable, // enables
  input wire uart_irq_fifo_pkg::fifo_ctrl_t fifo_ctrl, // fifo settings
  input wire logic divisor_access_bit, // divisor access
  input wire logic [15:0] baud_divisor // baud divisor
);
  import uart_irq_fifo_pkg::*;
  // decoded strobes of the two shared offsets
  wire ctl_wr = reg_wr && reg_addr == `OFS_IDENT_FIFO_CTRL;
  wire id_rd = reg_rd && reg_addr == `OFS_IDENT_FIFO_CTRL;
  wire en_wr = reg_wr && reg_addr == `OFS_IRQ_EN_DIV_HIGH;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  chk_flush_set: assert property (ctl_wr |=>
    flush == $past({reg_wdata[2], reg_wdata[1]}))
    else $error("flush pulse does not follow control write");
  chk_flush_idle: assert property (!ctl_wr |=> flush == 2'b00)
    else $error("flush pulse without control write");
  chk_fifo_ctrl_write: assert property (ctl_wr |=>
    fifo_ctrl == $past({reg_wdata[7:3], reg_wdata[0]})
    && fifos_enabled_flag == $past(reg_wdata[0]))
    else $error("fifo control not taken from write");
  chk_enable_write: assert property (
    en_wr && !divisor_access_bit |=>
    irq_enable == $past({reg_wdata[7], reg_wdata[3:0]}))
    else $error("interrupt enables not taken from write");
  chk_divisor_high: assert property (
    en_wr && divisor_access_bit |=>
    baud_divisor[15:8] == $past(reg_wdata[7:0]) && $stable(irq_enable))
    else $error("divisor high byte write misrouted");
  chk_ident_fifo: assert property (id_rd |=>
    reg_rdata[7:6] == {2{$past(fifos_enabled_flag)}})
    else $error("identification fifo state wrong");
  chk_line_irq: assert property (irq_enable.line_status_irq_en
    && cause.line_status |=> irq)
    else $error("enabled line status did not raise interrupt");
  // sampled reset keeps out the release edge, where rts still reads reset
  chk_rts_soft: assert property (arst_n && !auto_flow_en |=>
    rts_n == !$past(rts_request))
    else $error("rts does not follow software request");
  chk_read_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  chk_dma_rx_mode0: assert property (
    !fifo_ctrl.dma_signalling_select
    |=> dma_rx_req_n == ($past(rx_level) == '0))
    else $error("receive dma request wrong in mode 0");
endmodule
bind uart_irq_fifo_ctrl uart_irq_fifo_props #(.DEPTH(DEPTH), .LW(LW)) props (
  .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .cause, .rx_level, .auto_flow_en, .rts_request, .irq, .rts_n,
  .dma_rx_req_n, .flush, .fifos_enabled_flag, .irq_enable, .fifo_ctrl,
  .divisor_access_bit, .baud_divisor
);

// ---- verification/uart_irq_fifo_ctrl_tb.sv ----
// self-checking bench for the irq enable / fifo control block
`timescale 1ns/1ps
`include "uart_irq_fifo_map.svh"
module uart_irq_fifo_ctrl_tb;
  import uart_irq_fifo_pkg::*;
  localparam int LW = 5;
  localparam logic [31:0] A_EN = `OFS_IRQ_EN_DIV_HIGH;
  localparam logic [31:0] A_ID = `OFS_IDENT_FIFO_CTRL;
  localparam logic [31:0] A_LC = `OFS_LINE_CTRL;
  localparam logic [31:0] A_DL = `OFS_DIVISOR_LOW;
  logic ref_clk, arst_n, reg_wr, reg_rd, load, auto_flow_en, rts_request;
  logic irq, rts_n, dma_rx_req_n, dma_tx_req_n, rd_seen, tx_holding_empty;
  logic baud_x16_tick, baud_bit_tick;
  logic [31:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, baud_divisor, w, row;
  logic [LW-1:0] rx_level, tx_level, rx_set, tx_set;
  irq_cause_t cause, cause_set;
  flush_t flush;
  logic [15:0] exp_q[$];
  int n_mismatch, tests_run, cyc, nb, nt;
  int trig[4] = '{1, 4, 8, 14};
  int thr[4] = '{0, 2, 4, 8};
  // {cause, rx fill, tx fill, expected code}; last row runs with fifos on
  logic [15:0] pri[7] = '{16'hF106, 16'h7104, 16'h7002, 16'h7010,
    16'h3017, 16'h0011, 16'h201C};

  uart_irq_fifo_ctrl #(.DEPTH(16), .LW(LW)) uut (.ref_clk(ref_clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cause(cause),
    .rx_level(rx_level), .tx_level(tx_level),
    .tx_holding_empty(tx_holding_empty), .auto_flow_en(auto_flow_en),
    .rts_request(rts_request), .irq(irq), .rts_n(rts_n),
    .dma_rx_req_n(dma_rx_req_n), .dma_tx_req_n(dma_tx_req_n), .flush(flush),
    .fifos_enabled_flag(), .irq_enable(), .fifo_ctrl(),
    .divisor_access_bit(), .baud_divisor(baud_divisor),
    .baud_x16_tick(baud_x16_tick), .baud_bit_tick(baud_bit_tick));
  uart_fifo_peer #(.LW(LW)) peer (.ref_clk(ref_clk), .arst_n(arst_n),
    .load(load), .rx_set(rx_set), .tx_set(tx_set), .cause_set(cause_set),
    .flush(flush), .rx_level(rx_level), .tx_level(tx_level),
    .tx_holding_empty(tx_holding_empty), .cause(cause));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, exp, input string nm);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // an idle edge after each strobe, so no step drives a strobe twice
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // the read note goes on the queue before the strobe leaves
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  // peer needs one edge, the block one more; two spare edges for margin
  task automatic setp(input logic [3:0] c, input logic [LW-1:0] r, t);
    cause_set <= irq_cause_t'(c);
    rx_set <= r;
    tx_set <= t;
    load <= 1'b1;
    @(posedge ref_clk);
    load <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) rd_seen <= reg_rd;
  // read data compared mid-cycle, well after it has settled
  always @(negedge ref_clk) begin
    if (rd_seen === 1'b1) check(reg_rdata, exp_q.pop_front(), "rdata");
  end
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    arst_n = 1'b0;
    reg_addr = 32'h0;
    reg_wdata = 16'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    load = 1'b0;
    rx_set = '0;
    tx_set = '0;
    cause_set = '0;
    auto_flow_en = 1'b0;
    rts_request = 1'b1;
    void'($urandom(39));
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rd(A_EN, 16'h0000);
    rd(A_ID, 16'h0001);
    rd(A_LC, 16'h0000);
    rd(32'h50001110, 16'h0000);
    $display("test reset values done");
    repeat (4) begin
      w = 16'($urandom);
      wr(A_EN, w);
      rd(A_EN, w & 16'h008F);
    end
    $display("test enable bits done");
    row = 16'($urandom);
    wr(A_LC, 16'h0080);
    wr(A_EN, {8'h00, row[15:8]});
    wr(A_DL, {8'h00, row[7:0]});
    rd(A_EN, {8'h00, row[15:8]});
    rd(A_LC, 16'h0080);
    check(baud_divisor, row, "divisor");
    wr(A_LC, 16'h0000);
    rd(A_EN, w & 16'h008F);
    rd(A_DL, 16'h0000);
    $display("test divisor access done");
    // divisor 3: a sixteenth every 3 clocks, a bit every 48
    wr(A_LC, 16'h0080);
    wr(A_EN, 16'h0000);
    wr(A_DL, 16'h0003);
    wr(A_LC, 16'h0000);
    @(negedge ref_clk);
    while (baud_bit_tick !== 1'b1) @(negedge ref_clk);
    nb = 0;
    nt = 0;
    do begin
      @(negedge ref_clk);
      nb++;
      nt += baud_x16_tick;
    end while (baud_bit_tick !== 1'b1);
    @(posedge ref_clk);
    check(16'(nb), 16'(16 * 3), "bit period");
    check(16'(nt), 16'h0010, "sixteenths");
    $display("test baud ticks done");
    wr(A_EN, 16'h000F);
    wr(A_ID, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      row = pri[i];
      if (i == 6) wr(A_ID, 16'h0001);
      setp(row[15:12], LW'(row[11:8]), LW'(row[7:4]));
      rd(A_ID, {8'h00, (i == 6) ? 4'hC : 4'h0, row[3:0]});
      check(16'(irq), 16'(row[3:0] != 4'h1), "irq");
    end
    wr(A_EN, 16'h0000);
    setp(4'hE, 5'h01, 5'h00);
    rd(A_ID, 16'h00C1);
    check(16'(irq), 16'h0000, "irq masked");
    $display("test priority done");
    setp(4'h0, 5'h05, 5'h05);
    wr(A_ID, 16'h0007);
    repeat (2) @(posedge ref_clk);
    check(16'(rx_level), 16'h0000, "rx flush");
    check(16'(tx_level), 16'h0000, "tx flush");
    $display("test flush done");
    wr(A_EN, 16'h0001);
    auto_flow_en <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      wr(A_ID, 16'(t * 64 + 1));
      for (int k = 0; k < 2; k++) begin
        setp(4'h0, LW'(trig[t] - 1 + k), 5'h01);
        rd(A_ID, k ? 16'h00C4 : 16'h00C1);
        check(16'(rts_n), 16'(k), "rts_n");
        check(16'(dma_rx_req_n), 16'(trig[t] - 1 + k == 0), "dma rx");
      end
    end
    $display("test receive trigger done");
    wr(A_EN, 16'h0082);
    for (int t = 0; t < 4; t++) begin
      wr(A_ID, 16'(t * 16 + 9));
      for (int k = 0; k < 3; k++) begin
        setp(4'h0, 5'h00, k ? LW'(thr[t] + k - 1) : 5'h10);
        rd(A_ID, (k == 1) ? 16'h00C2 : 16'h00C1);
        check(16'(dma_tx_req_n), 16'(k == 0), "dma tx");
      end
    end
    $display("test transmit threshold done");
    repeat (3) @(posedge ref_clk);
    finish_test();
  end
endmodule
